/* hdl/sdm_consts.svh */
// Offsets, field positions, reset values and widths for the decimator block.
// Assumes byte-wide registers, each on its own aligned 32-bit AXI word.
`ifndef SDM_CONSTS_SVH
`define SDM_CONSTS_SVH

// --------------------------------------------------------------------------
// Register map (byte addresses)
// --------------------------------------------------------------------------
`define OFS_BLOCK_STRIDE 8'h20
`define OFS_FUNCTION     8'h00
`define OFS_INPUT        8'h04
`define OFS_OUTPUT       8'h08
`define OFS_LIVE_COUNT   8'h0c
`define OFS_PERIOD       8'h10
`define OFS_PULSE        8'h14
`define OFS_CONTROL      8'h18
`define OFS_SRC_SEL      8'h40
`define OFS_TIMING_SEL   8'h44
`define OFS_RATE_SHIFT   8'h48
`define OFS_RESULT_HIGH  8'h4c
`define OFS_RESULT_LOW   8'h50
`define OFS_STATUS       8'h54
`define OFS_MASK         8'h58
`define ADDR_BITS        8

// --------------------------------------------------------------------------
// Fields
// --------------------------------------------------------------------------
`define CTL_ENABLE_BIT   0
`define IN_CLOCK_HI      3
`define IN_CLOCK_LO      0
`define SRC_COL_HI       2
`define SRC_COL_LO       1
`define SRC_TSEL_BIT     0
`define TSEL_HI          2
`define TSEL_LO          1
`define RATE_HI          2
`define RATE_LO          0
`define SHIFT_HI         5
`define SHIFT_LO         4
`define STAT_READY_BIT   0

// --------------------------------------------------------------------------
// Reset values, encodings and counts
// --------------------------------------------------------------------------
`define RST_PERIOD       8'hff
`define RST_BYTE         8'h00
`define RESP_OKAY        2'b00
`define RESP_SLVERR      2'b10
`define NUM_CLK_SRC      16
`define NUM_BLOCKS       2

`endif

/* hdl/sdm_pkg.sv */
// Types shared by the decimator and timing generator.
// Assumes sdm_consts.svh supplies the numeric constants.
package sdm_pkg;

  typedef enum logic [1:0]
  {
    WR_COLLECT = 2'b01,
    WR_RESP    = 2'b10
  } wr_state_type;

  // Byte configuration of one 8-bit counter block
  typedef struct packed
  {
    logic [7:0] function_cfg;
    logic [7:0] input_cfg;
    logic [7:0] output_cfg;
    logic [7:0] period_value;
    logic [7:0] pulse_width;
    logic [7:0] control;
  } timer_cfg_type;

  // Decimator control bytes
  typedef struct packed
  {
    logic [7:0] source_select;
    logic [7:0] timing_select;
    logic [7:0] rate_shift;
  } filter_cfg_type;

endpackage

/* hdl/sigma_delta_decimator_timing.sv */
// Timing generator and sinc2 decimation filter for a one-bit modulator stream.
// Assumes clock sources arrive as one-cycle enables on aclk, synchronous
// comparator bits, and an AXI4-Lite master that keeps the usual handshakes.
//
// Function
// - Period register holds four times rate minus one
// - Terminal count: interrupt, capture, set data-ready
// - Four-bit input field picks one of sixteen clocks
// - Counter runs only while enable bit set
// - Rates 128/256 chain two blocks, upper enables
// - Pulse width compares count, shapes PWM high
// - Sinc2 filter, three controls, high/low results
// - Column field picks comparator bitstream feeding filter
// - Split timing field picks block driving capture
// - Rate field low bits, shift at 5:4
// - Pulse width zero or full halts samples
// - Data-ready stays until software clears it
//
// Local design decisions: the AXI4-Lite interface to the registers and the address map.
`timescale 1ns/100ps
`include "sdm_consts.svh"

module sigma_delta_decimator_timing
  import sdm_pkg::*;
#(
  parameter int NUM_COLUMNS = 4,
  parameter int ACC_W       = 24
)
(
  // Clock and reset
  input  wire logic                   aclk,
  input  wire logic                   aresetn,
  // AXI4-Lite write address
  input  wire logic [31:0]            s_axi_awaddr,
  input  wire logic                   s_axi_awvalid,
  output logic                        s_axi_awready,
  // AXI4-Lite write data
  input  wire logic [31:0]            s_axi_wdata,
  input  wire logic [3:0]             s_axi_wstrb,
  input  wire logic                   s_axi_wvalid,
  output logic                        s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0]                  s_axi_bresp,
  output logic                        s_axi_bvalid,
  input  wire logic                   s_axi_bready,
  // AXI4-Lite read address
  input  wire logic [31:0]            s_axi_araddr,
  input  wire logic                   s_axi_arvalid,
  output logic                        s_axi_arready,
  // AXI4-Lite read data
  output logic [31:0]                 s_axi_rdata,
  output logic [1:0]                  s_axi_rresp,
  output logic                        s_axi_rvalid,
  input  wire logic                   s_axi_rready,
  // Clock sources and modulator bitstreams
  input  wire logic [`NUM_CLK_SRC-1:0] clk_src_en,
  input  wire logic [NUM_COLUMNS-1:0] comparator_bits,
  // Outputs
  output logic                        pwm_out,
  output logic                        irq
);

  // --------------------------------------------------------------------------
  // Address decode
  // --------------------------------------------------------------------------
  // Returns 1 when the byte address names a mapped register
  function automatic logic addr_mapped(input logic [`ADDR_BITS-1:0] a);
    logic [`ADDR_BITS-1:0] r;
    r = a & (`OFS_BLOCK_STRIDE - 8'h01);
    if (a < (`OFS_BLOCK_STRIDE << 1))
      addr_mapped = (r <= `OFS_CONTROL) && (r[1:0] == 2'b00);
    else
      addr_mapped = (a >= `OFS_SRC_SEL) && (a <= `OFS_MASK) && (a[1:0] == 2'b00);
  endfunction

  // --------------------------------------------------------------------------
  // Registers
  // --------------------------------------------------------------------------
  timer_cfg_type               tcfg_q [`NUM_BLOCKS];
  filter_cfg_type              fcfg_q;
  logic [7:0]                  cnt_q [`NUM_BLOCKS];
  logic [15:0]                 result_q;
  logic [7:0]                  status_q;
  logic [7:0]                  mask_q;

  wr_state_type                wr_state_q;
  logic                        aw_got_q;
  logic                        w_got_q;
  logic [`ADDR_BITS-1:0]       awaddr_q;
  logic [7:0]                  wbyte_q;
  logic                        wlane_q;
  logic                        wr_fire;
  logic                        rd_fire;
  logic [`ADDR_BITS-1:0]       rd_addr;
  logic                        rd_clear;

  assign wr_fire  = (wr_state_q == WR_COLLECT) && aw_got_q && w_got_q;
  assign rd_fire  = s_axi_arvalid && s_axi_arready;
  assign rd_addr  = s_axi_araddr[`ADDR_BITS-1:0];
  // Reading the low byte completes a sample read and clears data-ready
  assign rd_clear = rd_fire && (rd_addr == `OFS_RESULT_LOW);

  // --------------------------------------------------------------------------
  // AXI write channel
  // --------------------------------------------------------------------------
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      wr_state_q    <= WR_COLLECT;
      aw_got_q      <= 1'b0;
      w_got_q       <= 1'b0;
      awaddr_q      <= '0;
      wbyte_q       <= `RST_BYTE;
      wlane_q       <= 1'b0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= `RESP_OKAY;
    end
    else
    begin
      case (wr_state_q)
        WR_COLLECT:
        begin
          s_axi_awready <= !aw_got_q && !(s_axi_awvalid && s_axi_awready);
          s_axi_wready  <= !w_got_q && !(s_axi_wvalid && s_axi_wready);
          if (s_axi_awvalid && s_axi_awready)
          begin
            aw_got_q <= 1'b1;
            awaddr_q <= s_axi_awaddr[`ADDR_BITS-1:0];
          end
          if (s_axi_wvalid && s_axi_wready)
          begin
            w_got_q <= 1'b1;
            wbyte_q <= s_axi_wdata[7:0];
            wlane_q <= s_axi_wstrb[0];
          end
          if (wr_fire)
          begin
            aw_got_q     <= 1'b0;
            w_got_q      <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= addr_mapped(awaddr_q) ? `RESP_OKAY : `RESP_SLVERR;
            wr_state_q   <= WR_RESP;
          end
        end
        WR_RESP:
        begin
          if (s_axi_bready)
          begin
            s_axi_bvalid <= 1'b0;
            wr_state_q   <= WR_COLLECT;
          end
        end
        default:
        begin
          wr_state_q <= WR_COLLECT;
        end
      endcase
    end
  end

  // --------------------------------------------------------------------------
  // Configuration bytes
  // --------------------------------------------------------------------------
  // Live count has no write path: it belongs to the counter alone
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      for (int b = 0; b < `NUM_BLOCKS; b++)
      begin
        tcfg_q[b] <= '0;
        tcfg_q[b].period_value <= `RST_PERIOD;
      end
      fcfg_q <= '0;
      mask_q <= `RST_BYTE;
    end
    else if (wr_fire && wlane_q)
    begin
      for (int b = 0; b < `NUM_BLOCKS; b++)
      begin
        case (awaddr_q - `ADDR_BITS'(b * `OFS_BLOCK_STRIDE))
          `OFS_FUNCTION: tcfg_q[b].function_cfg <= wbyte_q;
          `OFS_INPUT:    tcfg_q[b].input_cfg    <= wbyte_q;
          `OFS_OUTPUT:   tcfg_q[b].output_cfg   <= wbyte_q;
          `OFS_PERIOD:   tcfg_q[b].period_value <= wbyte_q;
          `OFS_PULSE:    tcfg_q[b].pulse_width  <= wbyte_q;
          `OFS_CONTROL:  tcfg_q[b].control      <= wbyte_q;
          default:       ;
        endcase
      end
      case (awaddr_q)
        `OFS_SRC_SEL:    fcfg_q.source_select <= wbyte_q;
        `OFS_TIMING_SEL: fcfg_q.timing_select <= wbyte_q;
        `OFS_RATE_SHIFT: fcfg_q.rate_shift    <= wbyte_q;
        `OFS_MASK:       mask_q               <= wbyte_q;
        default:         ;
      endcase
    end
  end

  // --------------------------------------------------------------------------
  // Timing generator
  // --------------------------------------------------------------------------
  logic [`NUM_BLOCKS-1:0] src_tick;
  logic                   chained;
  logic                   run0;
  logic                   tick0;
  logic                   low_zero;
  logic [15:0]            count16;
  logic [15:0]            period16;
  logic [15:0]            pulse16;
  logic                   width_ok;
  logic [`NUM_BLOCKS-1:0] block_tc;
  logic                   tc_ev;
  logic                   tsel;

  // Each block decodes a clock from the sixteen sources; only block 0's pick paces counting
  for (genvar g = 0; g < `NUM_BLOCKS; g++)
  begin : g_clk_mux
    assign src_tick[g] = clk_src_en[tcfg_q[g].input_cfg[`IN_CLOCK_HI:`IN_CLOCK_LO]];
  end

  // Upper block enable alone starts the chained 16-bit counter
  assign chained  = tcfg_q[1].control[`CTL_ENABLE_BIT];
  assign run0     = tcfg_q[0].control[`CTL_ENABLE_BIT] || chained;
  assign tick0    = run0 && src_tick[0];
  assign low_zero = (cnt_q[0] == 8'h00);
  assign count16  = chained ? {cnt_q[1], cnt_q[0]} : {8'h00, cnt_q[0]};
  assign period16 = chained ? {tcfg_q[1].period_value, tcfg_q[0].period_value}
                            : {8'h00, tcfg_q[0].period_value};
  assign pulse16  = chained ? {tcfg_q[1].pulse_width, tcfg_q[0].pulse_width}
                            : {8'h00, tcfg_q[0].pulse_width};
  // A stuck-high or stuck-low PWM would never mark a period boundary
  assign width_ok = (pulse16 != 16'h0000) && (pulse16 != period16);
  assign block_tc[0] = tick0 && low_zero && !chained;
  assign block_tc[1] = tick0 && low_zero && chained && (cnt_q[1] == 8'h00);
  assign tsel     = fcfg_q.source_select[`SRC_TSEL_BIT] ||
                    (fcfg_q.timing_select[`TSEL_HI:`TSEL_LO] != 2'b00);
  assign tc_ev    = block_tc[tsel] && width_ok;

  // Down-count from the period, reload at zero
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      cnt_q[0] <= `RST_PERIOD;
    else if (!run0)
      cnt_q[0] <= tcfg_q[0].period_value;
    else if (tick0)
      cnt_q[0] <= low_zero ? tcfg_q[0].period_value : cnt_q[0] - 8'h01;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      cnt_q[1] <= `RST_PERIOD;
    else if (!chained)
      cnt_q[1] <= tcfg_q[1].period_value;
    else if (tick0 && low_zero)
      cnt_q[1] <= (cnt_q[1] == 8'h00) ? tcfg_q[1].period_value : cnt_q[1] - 8'h01;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      pwm_out <= 1'b0;
    else
      pwm_out <= run0 && (count16 < pulse16);
  end

  // --------------------------------------------------------------------------
  // Sinc2 decimation filter
  // --------------------------------------------------------------------------
  logic [ACC_W-1:0] integ1_q;
  logic [ACC_W-1:0] integ2_q;
  logic [ACC_W-1:0] last2_q;
  logic [ACC_W-1:0] last_d1_q;
  logic [ACC_W-1:0] diff1;
  logic [ACC_W-1:0] diff2;
  logic [ACC_W-1:0] shifted;
  logic [1:0]       col_sel;
  logic             mod_bit;

  // Modular arithmetic: wrap in the integrators cancels in the combs
  assign col_sel = fcfg_q.source_select[`SRC_COL_HI:`SRC_COL_LO];
  assign mod_bit = comparator_bits[col_sel];
  assign diff1   = integ2_q - last2_q;
  assign diff2   = diff1 - last_d1_q;
  assign shifted = diff2 >> {fcfg_q.rate_shift[`SHIFT_HI:`SHIFT_LO], 1'b0};

  // The modulator is sampled on the same tick that paces the counter
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      integ1_q <= '0;
      integ2_q <= '0;
    end
    else if (tick0)
    begin
      integ1_q <= integ1_q + ACC_W'(mod_bit);
      integ2_q <= integ2_q + integ1_q;
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      last2_q   <= '0;
      last_d1_q <= '0;
      result_q  <= '0;
    end
    else if (tc_ev)
    begin
      last2_q   <= integ2_q;
      last_d1_q <= diff1;
      // One edge loads both bytes, regardless of an unread sample
      result_q  <= shifted[15:0];
    end
  end

  // --------------------------------------------------------------------------
  // Status and interrupt
  // --------------------------------------------------------------------------
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      status_q <= `RST_BYTE;
    else if (tc_ev)
      status_q[`STAT_READY_BIT] <= 1'b1;
    else if ((wr_fire && wlane_q && (awaddr_q == `OFS_STATUS) && wbyte_q[`STAT_READY_BIT]) || rd_clear)
      status_q[`STAT_READY_BIT] <= 1'b0;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      irq <= 1'b0;
    else
      irq <= |(status_q & mask_q);
  end

  // --------------------------------------------------------------------------
  // AXI read channel
  // --------------------------------------------------------------------------
  function automatic logic [7:0] read_byte(input logic [`ADDR_BITS-1:0] a);
    logic [7:0] v;
    v = 8'h00;
    for (int b = 0; b < `NUM_BLOCKS; b++)
    begin
      case (a - `ADDR_BITS'(b * `OFS_BLOCK_STRIDE))
        `OFS_FUNCTION:   v = tcfg_q[b].function_cfg;
        `OFS_INPUT:      v = tcfg_q[b].input_cfg;
        `OFS_OUTPUT:     v = tcfg_q[b].output_cfg;
        `OFS_LIVE_COUNT: v = cnt_q[b];
        `OFS_PERIOD:     v = tcfg_q[b].period_value;
        `OFS_PULSE:      v = tcfg_q[b].pulse_width;
        `OFS_CONTROL:    v = tcfg_q[b].control;
        default:         ;
      endcase
    end
    case (a)
      `OFS_SRC_SEL:     v = fcfg_q.source_select;
      `OFS_TIMING_SEL:  v = fcfg_q.timing_select;
      `OFS_RATE_SHIFT:  v = fcfg_q.rate_shift;
      `OFS_RESULT_HIGH: v = result_q[15:8];
      `OFS_RESULT_LOW:  v = result_q[7:0];
      `OFS_STATUS:      v = status_q;
      `OFS_MASK:        v = mask_q;
      default:          ;
    endcase
    if (!addr_mapped(a))
      v = 8'h00;
    read_byte = v;
  endfunction

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= '0;
      s_axi_rresp   <= `RESP_OKAY;
    end
    else if (rd_fire)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b1;
      s_axi_rdata   <= {24'h000000, read_byte(rd_addr)};
      s_axi_rresp   <= addr_mapped(rd_addr) ? `RESP_OKAY : `RESP_SLVERR;
    end
    else if (s_axi_rvalid && s_axi_rready)
    begin
      s_axi_rvalid  <= 1'b0;
    end
    else if (!s_axi_rvalid)
    begin
      s_axi_arready <= 1'b1;
    end
  end

endmodule

/* tb/sdm_far_side.sv */
// Far-side model: sixteen count-clock enables and the modulator bitstream.
// Assumes the bench routes one source to both counter and modulator column.
`timescale 1ns/100ps

module sdm_far_side
(
  // Clock
  input  wire logic       aclk,
  // Column clock choice
  input  wire logic [3:0] col_clk_sel,
  // Toward the decimator
  output logic      [15:0] clk_src_en,
  output logic      [3:0]  comparator_bits
);
  int unsigned cyc_q = 0;
  logic [7:0]  lfsr_q = 8'h5a;

  // Source i ticks once every i+1 cycles, so the period scales with the choice
  always_comb
    for (int i = 0; i < 16; i++)
      clk_src_en[i] = (cyc_q % (i + 1)) == 0;

  // Plain always: these variables also carry a start value
  always @(posedge aclk)
    cyc_q <= cyc_q + 1;

  // Bits move only on the column clock; a foreign clock would skew the stream
  always @(posedge aclk)
    if (clk_src_en[col_clk_sel])
      lfsr_q <= {lfsr_q[6:0], lfsr_q[7] ^ lfsr_q[5] ^ lfsr_q[4] ^ lfsr_q[3]};

  assign comparator_bits = lfsr_q[3:0];
endmodule

/* tb/sdm_chk.sv */
// Checker for bus answers and interrupt persistence at the decimator ports.
// Assumes one read and one write at most are in flight.
`timescale 1ns/100ps
`include "sdm_consts.svh"

module sdm_chk
(
  // Clock and reset
  input wire logic        aclk,
  input wire logic        aresetn,
  // Bus
  input wire logic [31:0] s_axi_awaddr,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic [31:0] s_axi_araddr,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0]  s_axi_rresp,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  // Interrupt
  input wire logic        irq
);
  logic aw_bad_q;
  logic ar_bad_q;

  // Gaps at 0x1c and 0x3c sit after each block register set
  function automatic logic bad(input logic [31:0] a);
    return a[7:0] > `OFS_MASK || a[1:0] != 2'b00 || (a[7:6] == 2'b00 && a[4:2] == 3'h7);
  endfunction

  always_ff @(posedge aclk)
  begin
    if (s_axi_awvalid && s_axi_awready)
      aw_bad_q <= bad(s_axi_awaddr);
    if (s_axi_arvalid && s_axi_arready)
      ar_bad_q <= bad(s_axi_araddr);
  end

  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);

  AST_BVALID_HOLD: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write answer dropped early");
  AST_BRESP_MAP: assert property (s_axi_bvalid |-> s_axi_bresp == (aw_bad_q ? `RESP_SLVERR : `RESP_OKAY))
    else $error("write answer code wrong");
  AST_READ_NEXT: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  AST_RDATA_HOLD: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data moved before accepted");
  AST_RRESP_MAP: assert property (s_axi_rvalid |-> s_axi_rresp == (ar_bad_q ? `RESP_SLVERR : `RESP_OKAY))
    else $error("read answer code wrong");
  AST_RDATA_BYTE: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0)
    else $error("read data upper bits set");
  AST_ONE_WRITE: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken while answer pending");
  AST_IRQ_STICKY: assert property ($fell(irq) |-> $past(s_axi_bvalid) || $past(s_axi_rvalid) || $past(s_axi_bvalid, 2))
    else $error("interrupt fell without software access");
endmodule

bind sigma_delta_decimator_timing sdm_chk sdm_chk_i (.*);

/* tb/test_sigma_delta_decimator_timing.sv */
// Self-checking bench: register map, timing period, pulse, chaining, interrupt.
// Assumes sdm_far_side supplies the clock sources and the modulator stream.
`timescale 1ns/100ps
`include "sdm_consts.svh"

module test_sigma_delta_decimator_timing
  import sdm_pkg::*;
;
  logic        aclk = 1'b0;
  logic        aresetn = 1'b0;
  logic [31:0] s_axi_awaddr = 32'h0, s_axi_wdata = 32'h0, s_axi_araddr = 32'h0, s_axi_rdata;
  logic [3:0]  s_axi_wstrb = 4'hf, comparator_bits, col_clk_sel = 4'h0;
  logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, pwm_out, irq;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic [15:0] clk_src_en;
  logic [33:0] exp_q[$];
  bit          care_q[$];
  logic [33:0] mon_e;
  bit          mon_c;
  logic        irq_d = 1'b0;
  logic [7:0]  v;
  logic [7:0]  rw_addr[10] = '{`OFS_FUNCTION, `OFS_INPUT, `OFS_OUTPUT, 8'h24, 8'h28, 8'h34,
                               `OFS_SRC_SEL, `OFS_TIMING_SEL, `OFS_RATE_SHIFT, `OFS_MASK};
  int          err_count = 0, checks = 0, cyc_n = 0, pwm_n = 0, rise_c = 0, rise_p = 0;
  int          gap_c = 0, gap_p = 0, src, per, pw;

  sigma_delta_decimator_timing sigma_delta_decimator_timing_i (.*);
  sdm_far_side sdm_far_side_i (.*);

  always #12.5 aclk = ~aclk;

  task automatic chk(input string what, input logic [33:0] e, input logic [33:0] g);
    checks++;
    if (g !== e)
    begin
      err_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, e, g);
    end
  endtask

  task automatic give_up(input bit hit, input string what);
    if (hit)
    begin
      err_count++;
      $display("CHECK FAILED %s wait expected 1 seen 0", what);
      conclude();
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [1:0] r = `RESP_OKAY);
    int n;
    bit busy;
    @(posedge aclk);
    n = 0;
    busy = 1'b1;
    exp_q.push_back({r, 32'h0});
    care_q.push_back(1'b0);
    s_axi_awaddr <= {24'h0, a};
    s_axi_wdata <= {24'h0, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (busy && n < 99)
    begin
      @(posedge aclk);
      n++;
      if (s_axi_awready)
        s_axi_awvalid <= 1'b0;
      if (s_axi_wready)
        s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid)
      begin
        s_axi_bready <= 1'b0;
        busy = 1'b0;
      end
    end
    give_up(busy, "write");
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] d, input bit c = 1'b1, input logic [1:0] r = `RESP_OKAY);
    int n;
    bit busy;
    @(posedge aclk);
    n = 0;
    busy = 1'b1;
    exp_q.push_back({r, 24'h0, d});
    care_q.push_back(c);
    s_axi_araddr <= {24'h0, a};
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    while (busy && n < 99)
    begin
      @(posedge aclk);
      n++;
      if (s_axi_arready)
        s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid)
      begin
        s_axi_rready <= 1'b0;
        busy = 1'b0;
      end
    end
    give_up(busy, "read");
  endtask

  task automatic wait_irq(input logic lv, input int lim, input bit must);
    int n;
    n = 0;
    while (irq !== lv && n < lim)
    begin
      @(posedge aclk);
      n++;
    end
    give_up(must && irq !== lv, "irq");
  endtask

  task automatic cfg(input logic [7:0] b, input logic [7:0] s, input logic [7:0] p, input logic [7:0] w,
                     input logic [7:0] e);
    wr(b + `OFS_INPUT, s);
    wr(b + `OFS_PERIOD, p);
    wr(b + `OFS_PULSE, w);
    wr(b + `OFS_CONTROL, e);
  endtask

  // Two rises apart: the first may follow the enable at any phase
  task automatic pcheck(input int gap, input int pwc);
    wait_irq(1'b1, gap * 2, 1'b1);
    wr(`OFS_STATUS, 8'h01);
    wait_irq(1'b0, 4, 1'b1);
    wait_irq(1'b1, gap * 2, 1'b1);
    // Let the rise watcher log this edge before its counts are read
    @(posedge aclk);
    chk("period", gap, gap_c);
    chk("pwm", pwc, gap_p);
  endtask

  task automatic conclude();
    $display("checks %0d mismatches %0d", checks, err_count);
    if (err_count == 0 && checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  // Answer checker and interrupt spacing watcher
  always @(posedge aclk)
  begin
    cyc_n++;
    pwm_n += int'(pwm_out === 1'b1);
    if (irq === 1'b1 && irq_d === 1'b0)
    begin
      gap_c = cyc_n - rise_c;
      gap_p = pwm_n - rise_p;
      rise_c = cyc_n;
      rise_p = pwm_n;
    end
    irq_d = irq;
    if (((s_axi_bvalid && s_axi_bready) || (s_axi_rvalid && s_axi_rready)) && exp_q.size() > 0)
    begin
      mon_e = exp_q.pop_front();
      mon_c = care_q.pop_front();
      if (s_axi_bvalid)
        chk("bresp", mon_e[33:32], s_axi_bresp);
      else
        chk("rdata", mon_c ? mon_e : {mon_e[33:32], 32'h0}, {s_axi_rresp, mon_c ? s_axi_rdata : 32'h0});
    end
  end

  initial
  begin
    void'($urandom(88));
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    rd(`OFS_PERIOD, `RST_PERIOD);
    rd(`OFS_BLOCK_STRIDE + `OFS_PERIOD, `RST_PERIOD);
    rd(`OFS_CONTROL, `RST_BYTE);
    wr(`OFS_LIVE_COUNT, 8'h12);
    rd(`OFS_LIVE_COUNT, 8'hff);
    wr(8'h5c, 8'h01, `RESP_SLVERR);
    rd(8'h1c, 8'h00, 1'b1, `RESP_SLVERR);
    $display("test reset_map done");
    foreach (rw_addr[i])
    begin
      v = 8'($urandom);
      wr(rw_addr[i], v);
      rd(rw_addr[i], v);
    end
    s_axi_wstrb <= 4'h0;
    wr(`OFS_MASK, ~v);
    s_axi_wstrb <= 4'hf;
    rd(`OFS_MASK, v);
    foreach (rw_addr[i])
      wr(rw_addr[i], 8'h00);
    $display("test registers done");
    wr(`OFS_MASK, 8'h01);
    cfg(`OFS_FUNCTION, 8'h00, 8'h30, 8'h08, 8'h00);
    wait_irq(1'b1, 200, 1'b0);
    chk("irq", 1'b0, irq);
    rd(`OFS_LIVE_COUNT, 8'h30);
    $display("test disabled done");
    src = $urandom % 16;
    per = 16 + $urandom % 48;
    pw = 1 + $urandom % (per - 1);
    col_clk_sel <= 4'(src);
    wr(`OFS_SRC_SEL, 8'($urandom) & 8'h06);
    wr(`OFS_RATE_SHIFT, 8'h32);
    cfg(`OFS_FUNCTION, 8'(src), 8'(per), 8'(pw), 8'h01);
    pcheck((per + 1) * (src + 1), pw * (src + 1));
    wr(`OFS_CONTROL, 8'h00);
    rd(`OFS_STATUS, 8'h01);
    rd(`OFS_RESULT_HIGH, 8'h00, 1'b0);
    rd(`OFS_RESULT_LOW, 8'h00, 1'b0);
    rd(`OFS_STATUS, 8'h00);
    chk("irq", 1'b0, irq);
    $display("test single_block done");
    for (int k = 0; k < 2; k++)
    begin
      cfg(`OFS_FUNCTION, 8'(src), 8'(per), k ? 8'(per) : 8'h00, 8'h01);
      wait_irq(1'b1, 3 * (per + 1) * (src + 1), 1'b0);
      chk("irq", 1'b0, irq);
    end
    wr(`OFS_CONTROL, 8'h00);
    $display("test halt_widths done");
    col_clk_sel <= 4'h0;
    wr(`OFS_MASK, 8'h00);
    wr(`OFS_SRC_SEL, 8'h01);
    cfg(`OFS_FUNCTION, 8'h00, 8'hff, 8'h10, 8'h00);
    cfg(`OFS_BLOCK_STRIDE, 8'h00, 8'h01, 8'h00, 8'h01);
    wait_irq(1'b1, 700, 1'b0);
    chk("irq", 1'b0, irq);
    rd(`OFS_STATUS, 8'h01);
    wr(`OFS_STATUS, 8'h01);
    wr(`OFS_MASK, 8'h01);
    pcheck(512, 16);
    $display("test chained done");
    conclude();
  end
endmodule
